// file: slip_status_pkg.sv
// Purpose: shared constants for the receive slip buffer and its status register
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: per-channel register block; channel decode lies outside
// Behaviour
// - status bit 4 is read-only and shows superframe-96 synchronisation, resetting to 0.
// - status bit 3 is read-only and shows the receive multiframe lock state, resetting to 0.
// - a write into an already full receive buffer sets the overflow flag in bit 2.
// - a read from an already empty receive buffer sets the underflow flag in bit 1.
// - either a full-buffer write or an empty-buffer read sets the frame slip flag in bit 0.
// - a write into a full buffer discards one whole buffered frame.
// - a read from an empty buffer outputs one whole frame a second time.
// - each slip flag stays set until the status register is read or written with a one in that bit, either of which clears it to 0.
`default_nettype none
package slip_status_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FILL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;

    localparam int BIT_SYNC96 = 4;
    localparam int BIT_MFLOCK = 3;
    localparam int BIT_OVERFLOW = 2;
    localparam int BIT_UNDERFLOW = 1;
    localparam int BIT_SLIP = 0;
    localparam int NUM_FLAGS = 3;
    localparam int CTRL_ENABLE = 0;

    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    localparam int FRAME_BYTES_DEF = 24;
    localparam int FRAMES_DEF = 2;
    localparam int DATA_W = 8;
endpackage
`default_nettype wire

// file: rx_slip_buffer_status.sv
// Purpose: receive slip buffer with frame slips and its sticky event status register
// Assumes: single clock; write and read strobes synchronous to I_CLK
// Notes: status flags clear on read and also on write-one-to-clear
//
// The implementer's own choices: the APB register port and the register addresses.
`default_nettype none
module rx_slip_buffer_status #(
    parameter int FRAME_BYTES = slip_status_pkg::FRAME_BYTES_DEF,
    parameter int FRAMES = slip_status_pkg::FRAMES_DEF
) (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_wr_valid,
    input wire logic [slip_status_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_rd_req,
    output logic [slip_status_pkg::DATA_W-1:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_superframe96_sync,
    input wire logic i_multiframe_lock,
    output logic o_irq
);
    localparam int DEPTH = FRAME_BYTES * FRAMES;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] FRAME_P = PW'(FRAME_BYTES);
    localparam logic [PW-1:0] LAST_P = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FRAME_C = CW'(FRAME_BYTES);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // refuse sizes the frame slip logic cannot serve
    if (FRAME_BYTES < 1 || FRAMES < 2) begin : g_bad_size
        $error("slip buffer needs at least two frames of one byte");
    end

    // pointer step with wrap for non power-of-two depth
    function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input logic [PW-1:0] d);
        logic [PW:0] s;
        s = {1'b0, p} + {1'b0, d};
        if (s >= (PW+1)'(DEPTH)) begin
            s = s - (PW+1)'(DEPTH);
        end
        return s[PW-1:0];
    endfunction

    function automatic logic [PW-1:0] ptr_sub(input logic [PW-1:0] p, input logic [PW-1:0] d);
        logic [PW:0] s;
        s = {1'b0, p} + (PW+1)'(DEPTH) - {1'b0, d};
        if (s >= (PW+1)'(DEPTH)) begin
            s = s - (PW+1)'(DEPTH);
        end
        return s[PW-1:0];
    endfunction

    logic [slip_status_pkg::DATA_W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic enable_r;
    logic [2:0] flags_r;
    logic [2:0] mask_r;
    logic [2:0] snap_r;
    logic [31:0] prdata_r;
    logic [slip_status_pkg::DATA_W-1:0] rd_data_r;
    logic rd_valid_r;

    // buffer state and slip detection
    wire do_wr = enable_r & i_wr_valid;
    wire do_rd = enable_r & i_rd_req;
    wire is_full = (count_r == DEPTH_C);
    wire is_empty = (count_r == '0);
    wire wr_slip = do_wr & is_full;
    wire rd_slip = do_rd & is_empty;

    wire [PW-1:0] rd_base = wr_slip ? ptr_add(rd_ptr_r, FRAME_P) :
                            rd_slip ? ptr_sub(rd_ptr_r, FRAME_P) : rd_ptr_r;
    wire [CW-1:0] count_base = wr_slip ? count_r - FRAME_C :
                               rd_slip ? count_r + FRAME_C : count_r;
    wire [CW-1:0] count_nxt = count_base + CW'(do_wr) - CW'(do_rd);
    wire [PW-1:0] rd_ptr_nxt = do_rd ? ptr_add(rd_base, PW'(1)) : rd_base;
    wire [PW-1:0] wr_ptr_nxt = do_wr ? ((wr_ptr_r == LAST_P) ? '0 : wr_ptr_r + PW'(1))
                                     : wr_ptr_r;

    // apb decode
    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable;
    wire hit_ctrl = (i_paddr == slip_status_pkg::ADDR_CTRL);
    wire hit_fill = (i_paddr == slip_status_pkg::ADDR_FILL);
    wire hit_status = (i_paddr == slip_status_pkg::ADDR_STATUS);
    wire hit_mask = (i_paddr == slip_status_pkg::ADDR_MASK);
    wire mapped = hit_ctrl | hit_fill | hit_status | hit_mask;
    wire wr_ctrl = access & i_pwrite & hit_ctrl;
    wire wr_mask = access & i_pwrite & hit_mask;
    wire wr_status = access & i_pwrite & hit_status;
    wire rd_status = access & ~i_pwrite & hit_status;

    logic [2:0] flag_set;
    always_comb begin
        flag_set = '0;
        flag_set[slip_status_pkg::BIT_OVERFLOW] = wr_slip;
        flag_set[slip_status_pkg::BIT_UNDERFLOW] = rd_slip;
        flag_set[slip_status_pkg::BIT_SLIP] = wr_slip | rd_slip;
    end
    // clear only bits seen by this read
    wire [2:0] clr_read = rd_status ? snap_r : 3'h0;
    wire [2:0] clr_write = wr_status ? i_pwdata[2:0] : 3'h0;
    wire [2:0] flags_nxt = (flags_r & ~clr_read & ~clr_write) | flag_set;

    logic [7:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[slip_status_pkg::NUM_FLAGS-1:0] = flags_r;
        status_word[slip_status_pkg::BIT_SYNC96] = i_superframe96_sync;
        status_word[slip_status_pkg::BIT_MFLOCK] = i_multiframe_lock;
    end
    wire [31:0] read_mux = hit_ctrl ? 32'(enable_r) :
                           hit_fill ? 32'(count_r) :
                           hit_status ? 32'(status_word) :
                           hit_mask ? 32'(mask_r) : 32'h0;

    always_ff @(posedge I_CLK) begin
        if (do_wr) begin
            mem[wr_ptr_r] <= i_wr_data;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (!enable_r) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rd_data_r <= '0;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r <= do_rd ? mem[rd_base] : rd_data_r;
            rd_valid_r <= do_rd;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            flags_r <= slip_status_pkg::FLAGS_RESET;
            mask_r <= slip_status_pkg::MASK_RESET;
            enable_r <= slip_status_pkg::CTRL_ENABLE_RESET;
            snap_r <= '0;
            prdata_r <= '0;
        end else begin
            flags_r <= flags_nxt;
            mask_r <= wr_mask ? i_pwdata[2:0] : mask_r;
            enable_r <= wr_ctrl ? i_pwdata[slip_status_pkg::CTRL_ENABLE] : enable_r;
            snap_r <= setup ? flags_r : snap_r;
            prdata_r <= setup ? read_mux : prdata_r;
        end
    end

    // read data is captured in the setup cycle, so every access takes one wait-free cycle
    assign o_prdata = prdata_r;
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~mapped;
    assign o_rd_data = rd_data_r;
    assign o_rd_valid = rd_valid_r;
    assign o_irq = |(flags_r & mask_r);
endmodule
`default_nettype wire

// file: rx_slip_buffer_status_monitor.sv
// Purpose: port checker for rx_slip_buffer_status
// Assumes: status word at 8'h08, zero wait states
// Notes: bound to every instance at the foot
`default_nettype none
module rx_slip_buffer_status_monitor (
    input wire logic I_CLK, I_RSTN, i_psel, i_penable, i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready, o_pslverr, i_wr_valid, i_rd_req, o_rd_valid, o_irq,
    input wire logic [7:0] o_rd_data,
    input wire logic i_superframe96_sync, i_multiframe_lock
);
    wire acc = i_psel && i_penable;
    wire st = acc && !i_pwrite && i_paddr == 8'h08;
    wire ev = i_wr_valid || i_rd_req;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    AST_SYNC: assert property (st |-> o_prdata[4] == $past(i_superframe96_sync))
        else $error("sync bit wrong");
    AST_MFLOCK: assert property (st |-> o_prdata[3] == $past(i_multiframe_lock))
        else $error("lock bit wrong");
    AST_SLIP: assert property (st |-> o_prdata[0] == |o_prdata[2:1])
        else $error("slip flag without cause");
    AST_CLR: assert property (!ev ##1 st && !ev ##1 !ev [*2] ##1 st |-> o_prdata[2:0] == 3'h0)
        else $error("flags survive a read");
    AST_SLVERR: assert property (acc && i_paddr > 8'h0c |-> o_pslverr) else $error("no slverr");
    AST_RDY: assert property (acc |-> o_pready) else $error("pready low");
    AST_RDV: assert property (o_rd_valid |-> $past(i_rd_req))
        else $error("read data without request");
    AST_HOLD: assert property (!o_rd_valid |-> $stable(o_rd_data)) else $error("rd data moved");
    cover property (st && o_prdata[2]);
    cover property (st && o_prdata[1]);
    cover property (o_irq);
endmodule
bind rx_slip_buffer_status rx_slip_buffer_status_monitor i_mon (.*);
`default_nettype wire

// file: rx_slip_buffer_status_tb_top.sv
// Purpose: self-checking bench for rx_slip_buffer_status
// Assumes: zero-wait apb slave, four-byte frames for speed
// Notes: random bytes from a fixed seed
`default_nettype none
module rx_slip_buffer_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FB = 4;
    logic clk = 0, rstn = 0, sel = 0, en = 0, wr = 0, wv = 0, rq = 0, sy = 0, ml = 0, er;
    logic [7:0] adr = 8'h00, wd = 8'h00, rdat;
    logic [31:0] pw = 32'h0, rd, prd;
    logic rdy, err, rv, irq;
    int n_mismatch = 0, check_count = 0;
    always #20 clk = ~clk;
    rx_slip_buffer_status #(.FRAME_BYTES(FB), .FRAMES(2)) i_dut (.I_CLK(clk), .I_RSTN(rstn),
        .i_psel(sel), .i_penable(en), .i_pwrite(wr), .i_paddr(adr), .i_pwdata(pw),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_wr_valid(wv), .i_wr_data(wd),
        .i_rd_req(rq), .o_rd_data(rdat), .o_rd_valid(rv), .i_superframe96_sync(sy),
        .i_multiframe_lock(ml), .o_irq(irq));
    function automatic logic [31:0] st(logic s, logic m, logic [2:0] f);
        return {27'h0, s, m, f};
    endfunction
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {sel, en, wr, adr, pw} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        en <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        er = err;
        {sel, en} <= 2'b00;
    endtask
    task automatic wb(logic [7:0] d);
        @(posedge clk);
        {wv, wd} <= {1'b1, d};
        @(posedge clk);
        wv <= 0;
    endtask
    task automatic rb(int e);
        @(posedge clk);
        rq <= 1;
        @(posedge clk);
        rq <= 0;
        #1;
        chk("rd_valid", 1, rv);
        if (e >= 0) chk("rd_data", e, rdat);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        logic [7:0] b[9];
        void'($urandom(32'he23bd7fc));
        repeat (16) @(posedge clk);
        rstn <= 1;
        apb(0, 8'h08, 0);
        chk("status", st(0, 0, 0), rd);
        apb(0, 8'h0c, 0);
        chk("mask", 0, rd);
        apb(0, 8'h00, 0);
        chk("ctrl", 1, rd);
        for (int i = 0; i < 4; i++) begin
            {ml, sy} <= i[1:0];
            apb(0, 8'h08, 0);
            chk("status", st(i[0], i[1], 0), rd);
        end
        $display("test lock bits done");
        foreach (b[i]) b[i] = 8'($urandom);
        for (int i = 0; i < FB; i++) wb(b[i]);
        for (int i = 0; i < FB; i++) rb(b[i]);
        rb(b[0]);
        apb(0, 8'h08, 0);
        chk("status", st(1, 1, 3'h3), rd);
        apb(0, 8'h08, 0);
        chk("status", st(1, 1, 3'h0), rd);
        $display("test underflow done");
        apb(1, 8'h00, 0);
        apb(1, 8'h00, 1);
        foreach (b[i]) wb(b[i]);
        apb(0, 8'h04, 0);
        chk("fill", FB + 1, rd);
        for (int i = FB; i < 9; i++) rb(b[i]);
        apb(0, 8'h08, 0);
        chk("status", st(1, 1, 3'h5), rd);
        $display("test overflow done");
        apb(1, 8'h0c, 7);
        rb(-1);
        chk("irq", 1, irq);
        apb(1, 8'h08, 7);
        #1 chk("irq", 0, irq);
        apb(1, 8'h0c, 0);
        rb(-1);
        chk("irq", 0, irq);
        apb(0, 8'h10, 0);
        chk("unmapped", 0, rd);
        chk("pslverr", 1, er);
        $display("test irq and decode done");
        finish_test;
    end
    initial begin
        #2000000;
        n_mismatch++;
        finish_test;
    end
endmodule
`default_nettype wire
